// >>> logic/spld_top.sv
// Synthesiser core: memory read sequencer, channel latches, dividers, phase detector
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
module spld_top #(
   parameter int unsigned POWER_ON_DELAY = spld_pkg::POWER_ON_CYCLES,
   parameter int unsigned MEM_WAKE       = spld_pkg::MEM_WAKE_CYCLES,
   parameter int unsigned LOCK_WINDOW    = spld_pkg::LOCK_WINDOW_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   input  wire logic [3:0]  nibble_in_i,
   input  wire logic        program_trigger_i,
   input  wire logic        prescaled_input_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   output logic      [2:0]  word_select_o,
   output logic             word_select_oe_o,
   output logic             memory_power_enable_n_o,
   output logic             memory_power_enable_oe_o,
   output logic             prescaler_modulus_select_o,
   output logic             coarse_phase_out_o,
   output logic             coarse_phase_oe_o,
   output logic             lock_indicator_n_o,
   output logic             lock_indicator_oe_o
);
   if (POWER_ON_DELAY < 1 || POWER_ON_DELAY > 65535) begin : g_chk_por
      $error("POWER_ON_DELAY out of range");
   end
   if (MEM_WAKE < 1 || MEM_WAKE > 65535) begin : g_chk_wake
      $error("MEM_WAKE out of range");
   end
   if (LOCK_WINDOW < 1 || LOCK_WINDOW > 255) begin : g_chk_lock
      $error("LOCK_WINDOW out of range");
   end

   spld_cnt_if cnt ();

   spld_ref_div u_ref (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .cnt       (cnt.ref_side)
   );

   spld_swallow_cnt u_var (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .cnt       (cnt.var_side)
   );

   // ---------------- Read sequencer ----------------
   spld_pkg::spld_seq_t state_reg;
   spld_pkg::spld_seq_t state_next;
   logic [5:0]  pdiv_reg;
   logic [5:0]  pdiv_next;
   logic [3:0]  slot_reg;
   logic [3:0]  slot_next;
   logic [15:0] wait_reg;
   logic [15:0] wait_next;
   logic [15:0] por_reg;
   logic [15:0] por_next;
   logic        por_done_reg;
   logic        por_done_next;
   logic        trig_d_reg;
   logic        trig_d_next;
   logic        cyclic_reg;
   logic        cyclic_next;
   logic [3:0]  word_mem [0:7];
   logic [3:0]  word_wr_val;
   logic        word_wr;
   logic [10:0] ref_reg;
   logic [10:0] ref_next;
   logic [9:0]  main_reg;
   logic [9:0]  main_next;
   logic [6:0]  swal_reg;
   logic [6:0]  swal_next;
   logic        load_reg;
   logic        load_next;
   logic        fin_d_reg;
   logic        fin_edge_reg;
   logic [2:0]  ws_reg;
   logic [2:0]  ws_next;
   logic        ws_oe_reg;
   logic        ws_oe_next;
   logic        me_oe_reg;
   logic        me_oe_next;
   logic        pclk_en;
   logic        start;
   logic        soft_trig;

   assign soft_trig = reg_wr_i && reg_addr_i == spld_pkg::OFS_CTRL
                      && reg_wdata_i[spld_pkg::CTRL_TRIG_BIT];

   always_comb begin
      pdiv_next     = pdiv_reg + 6'h01;
      pclk_en       = (pdiv_reg == 6'(spld_pkg::PCLK_DIV - 1));
      trig_d_next   = program_trigger_i;
      por_next      = por_reg;
      por_done_next = por_done_reg;
      state_next    = state_reg;
      slot_next     = slot_reg;
      wait_next     = wait_reg;
      cyclic_next   = cyclic_reg;
      ref_next      = ref_reg;
      main_next     = main_reg;
      swal_next     = swal_reg;
      load_next     = 1'b0;
      word_wr       = 1'b0;
      word_wr_val   = nibble_in_i;
      if (!por_done_reg) begin
         por_next = por_reg - 16'h0001;
         if (por_reg == 16'h0000) begin
            por_done_next = 1'b1;
         end
      end
      start = (program_trigger_i != trig_d_reg) || soft_trig
              || (!por_done_reg && por_reg == 16'h0000);
      unique case (state_reg)
         spld_pkg::SPLD_IDLE: begin
            if (start) begin
               state_next = spld_pkg::SPLD_WAKE;
               wait_next  = 16'(MEM_WAKE - 1);
            end
         end
         spld_pkg::SPLD_WAKE: begin
            // give memory time to power up
            wait_next = wait_reg - 16'h0001;
            if (wait_reg == 16'h0000) begin
               state_next = spld_pkg::SPLD_READ;
               slot_next  = 4'h0;
            end
         end
         spld_pkg::SPLD_READ: begin
            if (pclk_en) begin
               slot_next = slot_reg + 4'h1;
               if (slot_reg[0]) begin
                  word_wr = 1'b1;
               end
               if (slot_reg == 4'(spld_pkg::SLOTS_PER_READ - 1)) begin
                  main_next = {word_mem[2], word_mem[1], word_mem[0][3:2]};
                  swal_next = {word_mem[4][2:0], word_mem[3]};
                  ref_next  = {nibble_in_i[2:0], word_mem[6], word_mem[5]};
                  load_next = 1'b1;
                  cyclic_next = !program_trigger_i;
                  if (program_trigger_i) begin
                     state_next = spld_pkg::SPLD_IDLE;
                  end
               end
            end
         end
         default: begin
            state_next = spld_pkg::SPLD_IDLE;
         end
      endcase
      me_oe_next = (state_next != spld_pkg::SPLD_IDLE);
      ws_oe_next = (state_next == spld_pkg::SPLD_READ);
      ws_next    = (state_next == spld_pkg::SPLD_READ) ? slot_next[3:1] : 3'h0;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg    <= spld_pkg::SPLD_IDLE;
         pdiv_reg     <= 6'h00;
         slot_reg     <= 4'h0;
         wait_reg     <= 16'h0000;
         por_reg      <= 16'(POWER_ON_DELAY - 1);
         por_done_reg <= 1'b0;
         trig_d_reg   <= 1'b1;
         cyclic_reg   <= 1'b0;
         ref_reg      <= 11'h000;
         main_reg     <= 10'h000;
         swal_reg     <= 7'h00;
         load_reg     <= 1'b0;
         ws_reg       <= 3'h0;
         ws_oe_reg    <= 1'b0;
         me_oe_reg    <= 1'b0;
      end else begin
         state_reg    <= state_next;
         pdiv_reg     <= pdiv_next;
         slot_reg     <= slot_next;
         wait_reg     <= wait_next;
         por_reg      <= por_next;
         por_done_reg <= por_done_next;
         trig_d_reg   <= trig_d_next;
         cyclic_reg   <= cyclic_next;
         ref_reg      <= ref_next;
         main_reg     <= main_next;
         swal_reg     <= swal_next;
         load_reg     <= load_next;
         ws_reg       <= ws_next;
         ws_oe_reg    <= ws_oe_next;
         me_oe_reg    <= me_oe_next;
      end
   end

   // Intermediate word latches
   always_ff @(posedge clk_sys_i) begin
      if (word_wr) begin
         word_mem[slot_reg[3:1]] <= word_wr_val;
      end
   end

   // Prescaled input edge, one cycle pulse
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         fin_d_reg    <= 1'b0;
         fin_edge_reg <= 1'b0;
      end else begin
         fin_d_reg    <= prescaled_input_i;
         fin_edge_reg <= prescaled_input_i && !fin_d_reg;
      end
   end

   assign cnt.ref_val  = ref_reg;
   assign cnt.main_val = main_reg;
   assign cnt.swal_val = swal_reg;
   assign cnt.load     = load_reg;
   assign cnt.fin_edge = fin_edge_reg;

   // ---------------- Phase/frequency detector ----------------
   logic       up_reg;
   logic       up_next;
   logic       dn_reg;
   logic       dn_next;
   logic [7:0] gap_reg;
   logic [7:0] gap_next;
   logic       lock_reg;
   logic       lock_next;
   logic       pd_out_reg;
   logic       pd_out_next;
   logic       pd_oe_reg;
   logic       pd_oe_next;

   always_comb begin
      up_next   = up_reg || cnt.var_tick;
      dn_next   = dn_reg || cnt.ref_tick;
      gap_next  = gap_reg;
      lock_next = lock_reg;
      if (up_next && dn_next) begin
         up_next = 1'b0;
         dn_next = 1'b0;
         // Pair closed: in window means locked
         lock_next = (gap_reg < 8'(LOCK_WINDOW));
         gap_next  = 8'h00;
      end else if (up_next || dn_next) begin
         if (gap_reg != 8'hFF) begin
            gap_next = gap_reg + 8'h01;
         end
         if (gap_reg >= 8'(LOCK_WINDOW)) begin
            lock_next = 1'b0;
         end
      end
      pd_out_next = up_next;
      pd_oe_next  = (up_next || dn_next) && !lock_next;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         up_reg     <= 1'b0;
         dn_reg     <= 1'b0;
         gap_reg    <= 8'h00;
         lock_reg   <= 1'b0;
         pd_out_reg <= 1'b0;
         pd_oe_reg  <= 1'b0;
      end else begin
         up_reg     <= up_next;
         dn_reg     <= dn_next;
         gap_reg    <= gap_next;
         lock_reg   <= lock_next;
         pd_out_reg <= pd_out_next;
         pd_oe_reg  <= pd_oe_next;
      end
   end

   // ---------------- Register port ----------------
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            spld_pkg::OFS_STATUS: begin
               rdata_next[spld_pkg::STAT_BUSY_BIT]   = (state_reg != spld_pkg::SPLD_IDLE);
               rdata_next[spld_pkg::STAT_CYCLIC_BIT] = cyclic_reg;
               rdata_next[spld_pkg::STAT_LOCK_BIT]   = lock_reg;
               rdata_next[spld_pkg::STAT_MOD_BIT]    = cnt.mod_sel;
            end
            spld_pkg::OFS_CHANNEL: begin
               rdata_next[spld_pkg::CHAN_MAIN_LSB +: 10] = main_reg;
               rdata_next[spld_pkg::CHAN_SWAL_LSB +: 7]  = swal_reg;
               rdata_next[spld_pkg::CHAN_REF_LSB +: 11]  = ref_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_o                = rdata_reg;
   assign word_select_o              = ws_reg;
   assign word_select_oe_o           = ws_oe_reg;
   assign memory_power_enable_n_o    = !me_oe_reg;
   assign memory_power_enable_oe_o   = me_oe_reg;
   assign prescaler_modulus_select_o = cnt.mod_sel;
   assign coarse_phase_out_o         = pd_out_reg;
   assign coarse_phase_oe_o          = pd_oe_reg;
   assign lock_indicator_n_o         = !lock_reg;
   assign lock_indicator_oe_o        = lock_reg;
endmodule // spld_top

// >>> logic/spld_pkg.sv
// Constants and helpers shared by the synthesiser program loader and divider
package spld_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned PCLK_DIV        = 64;
   localparam int unsigned SLOTS_PER_READ  = 16;
   localparam int unsigned WORDS_PER_READ  = 8;
   localparam int unsigned POWER_ON_CYCLES = 53248;
   localparam int unsigned MEM_WAKE_NS     = 25000;
   // Least time, so round up
   localparam int unsigned MEM_WAKE_CYCLES =
      (MEM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOCK_WINDOW_CYCLES = 4;

   localparam int unsigned REF_W   = 11;
   localparam int unsigned MAIN_W  = 10;
   localparam int unsigned SWAL_W  = 7;
   localparam logic [10:0] REF_MIN  = 11'h006;
   localparam logic [9:0]  MAIN_MIN = 10'h003;

   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_CHANNEL = 8'h08;
   localparam int unsigned CTRL_TRIG_BIT   = 0;
   localparam int unsigned STAT_BUSY_BIT   = 0;
   localparam int unsigned STAT_CYCLIC_BIT = 1;
   localparam int unsigned STAT_LOCK_BIT   = 2;
   localparam int unsigned STAT_MOD_BIT    = 3;
   localparam int unsigned CHAN_MAIN_LSB   = 0;
   localparam int unsigned CHAN_SWAL_LSB   = 10;
   localparam int unsigned CHAN_REF_LSB    = 17;

   typedef enum logic [1:0] {
      SPLD_IDLE = 2'b00,
      SPLD_WAKE = 2'b01,
      SPLD_READ = 2'b10
   } spld_seq_t;

   // Raise a value below the least legal count to that count
   function automatic logic [10:0] spld_floor11(input logic [10:0] v, input logic [10:0] lo);
      spld_floor11 = (v < lo) ? lo : v;
   endfunction
endpackage

// >>> logic/spld_cnt_if.sv
// Carrier between the loader and the two divider chains
`timescale 1ns/10ps
interface spld_cnt_if;
   logic [10:0] ref_val;
   logic [9:0]  main_val;
   logic [6:0]  swal_val;
   logic        load;
   logic        fin_edge;
   logic        ref_tick;
   logic        var_tick;
   logic        mod_sel;

   modport ctl (output ref_val, main_val, swal_val, load, fin_edge,
                input  ref_tick, var_tick, mod_sel);
   modport ref_side (input ref_val, load, output ref_tick);
   modport var_side (input main_val, swal_val, load, fin_edge,
                     output var_tick, mod_sel);
endinterface

// >>> logic/spld_ref_div.sv
// Reference divider: one tick every twice the programmed count with its LSB cleared, never below twice REF_MIN
`timescale 1ns/10ps
module spld_ref_div (
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   spld_cnt_if.ref_side cnt
);
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic        tick_reg;
   logic        tick_next;
   logic [10:0] ref_eff;

   always_comb begin
      ref_eff   = spld_pkg::spld_floor11({cnt.ref_val[10:1], 1'b0}, spld_pkg::REF_MIN);
      tick_next = 1'b0;
      cnt_next  = cnt_reg - 12'h001;
      if (cnt.load || cnt_reg == 12'h000) begin
         cnt_next  = {ref_eff, 1'b0} - 12'h001;
         tick_next = !cnt.load;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cnt_reg  <= 12'h00B;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign cnt.ref_tick = tick_reg;
endmodule // spld_ref_div

// >>> logic/spld_swallow_cnt.sv
// Main and swallow counters driving the prescaler modulus line
`timescale 1ns/10ps
module spld_swallow_cnt (
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   spld_cnt_if.var_side cnt
);
   logic [9:0] main_reg;
   logic [9:0] main_next;
   logic [6:0] swal_reg;
   logic [6:0] swal_next;
   logic       mod_reg;
   logic       mod_next;
   logic       tick_reg;
   logic       tick_next;
   logic [9:0] main_eff;

   always_comb begin
      main_eff  = (cnt.main_val < spld_pkg::MAIN_MIN) ? spld_pkg::MAIN_MIN : cnt.main_val;
      main_next = main_reg;
      swal_next = swal_reg;
      mod_next  = mod_reg;
      tick_next = 1'b0;
      if (cnt.load) begin
         main_next = main_eff - 10'h001;
         swal_next = cnt.swal_val;
         mod_next  = (cnt.swal_val == 7'h00);
      end else if (cnt.fin_edge) begin
         if (main_reg == 10'h000) begin
            main_next = main_eff - 10'h001;
            swal_next = cnt.swal_val;
            mod_next  = (cnt.swal_val == 7'h00);
            tick_next = 1'b1;
         end else begin
            main_next = main_reg - 10'h001;
            if (!mod_reg) begin
               swal_next = swal_reg - 7'h01;
               mod_next  = (swal_reg == 7'h01);
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         main_reg <= 10'h002;
         swal_reg <= 7'h00;
         mod_reg  <= 1'b1;
         tick_reg <= 1'b0;
      end else begin
         main_reg <= main_next;
         swal_reg <= swal_next;
         mod_reg  <= mod_next;
         tick_reg <= tick_next;
      end
   end

   assign cnt.var_tick = tick_reg;
   assign cnt.mod_sel  = mod_reg;
endmodule // spld_swallow_cnt

// >>> testbench/spld_top_asserts.sv
// Checker for the read sequencer, memory enable and lock outputs
`timescale 1ns/10ps
module spld_top_asserts #(
   parameter int unsigned MEM_WAKE = spld_pkg::MEM_WAKE_CYCLES
) (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic       program_trigger_i,
   input  wire logic [2:0] word_select_o,
   input  wire logic       word_select_oe_o,
   input  wire logic       memory_power_enable_n_o,
   input  wire logic       memory_power_enable_oe_o,
   input  wire logic       coarse_phase_oe_o,
   input  wire logic       lock_indicator_n_o,
   input  wire logic       lock_indicator_oe_o
);
   logic [2:0] ws_reg;
   int         hold_reg;
   int         hold_next;
   int         wake_reg;
   int         wake_next;
   logic       seen_reg;
   logic       seen_next;
   logic       chg;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   always_comb begin
      chg       = word_select_oe_o && (word_select_o != ws_reg);
      hold_next = chg ? 0 : hold_reg + 1;
      seen_next = word_select_oe_o && (seen_reg || chg);
      wake_next = !memory_power_enable_oe_o ? 0 : wake_reg + (word_select_oe_o ? 0 : 1);
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ws_reg   <= 3'h0;
         hold_reg <= 0;
         seen_reg <= 1'b0;
         wake_reg <= 0;
      end else begin
         ws_reg   <= word_select_o;
         hold_reg <= hold_next;
         seen_reg <= seen_next;
         wake_reg <= wake_next;
      end
   end

   a_mem_low: assert property (memory_power_enable_oe_o |-> !memory_power_enable_n_o)
      else $error("memory enable driven but not low");
   a_ws_in_read: assert property (word_select_oe_o |-> memory_power_enable_oe_o)
      else $error("word select driven without memory enable");
   a_ws_step: assert property (chg |-> word_select_o == ws_reg + 3'h1)
      else $error("word select did not step up by one");
   a_ws_hold: assert property (chg && seen_reg |-> hold_reg == 127)
      else $error("word slot length is not two program clocks");
   a_ws_last: assert property ($fell(word_select_oe_o) |-> ws_reg == 3'h7)
      else $error("word select released before the last word");
   a_mem_release: assert property ($fell(word_select_oe_o) |-> $fell(memory_power_enable_oe_o))
      else $error("memory enable not released with word select");
   a_wake_len: assert property ($rose(word_select_oe_o) |-> wake_reg == MEM_WAKE)
      else $error("memory wake period has wrong length");
   a_trig_start: assert property ($changed(program_trigger_i) && !memory_power_enable_oe_o
      |-> ##[1:8] memory_power_enable_oe_o)
      else $error("trigger edge did not start a read");
   a_lock_pair: assert property (lock_indicator_oe_o |-> !lock_indicator_n_o && !coarse_phase_oe_o)
      else $error("lock shown while coarse output active");

   c_read: cover property ($rose(word_select_oe_o));
   c_wrap: cover property (chg && ws_reg == 3'h7);
   c_lock: cover property (lock_indicator_oe_o);
endmodule // spld_top_asserts

// >>> testbench/spld_mem_model.sv
// Channel memory and dual-modulus prescaler facing the core
`timescale 1ns/10ps
module spld_mem_model #(
   parameter int unsigned WAKE = 3
) (
   input  wire logic        clk_sys_i,
   input  wire logic [27:0] channel_i,
   input  wire logic [2:0]  word_select_i,
   input  wire logic        word_select_oe_i,
   input  wire logic        mem_on_i,
   input  wire logic        modulus_i,
   output logic      [3:0]  nibble_o,
   output logic             prescaled_o
);
   logic [3:0] words [8];
   int         awake = 0;
   int         div   = 0;

   always_comb begin
      words[0] = {channel_i[1:0], 2'h3};
      words[1] = channel_i[5:2];
      words[2] = channel_i[9:6];
      words[3] = channel_i[13:10];
      words[4] = {1'h1, channel_i[16:14]};
      words[5] = channel_i[20:17];
      words[6] = channel_i[24:21];
      words[7] = {1'h1, channel_i[27:25]};
   end

   always @(posedge clk_sys_i) begin
      awake <= mem_on_i ? awake + 1 : 0;
      div   <= (div == 0) ? (modulus_i ? 3 : 4) : div - 1;
   end

   // Pull-ups show while memory is off or still waking
   assign nibble_o = (mem_on_i && word_select_oe_i && awake >= WAKE) ?
                     words[word_select_i] : 4'hF;
   assign prescaled_o = (div < 2);
endmodule // spld_mem_model

// >>> testbench/tb.sv
// Bench for the synthesiser core with memory and prescaler model
`timescale 1ns/10ps
module tb;
   localparam int unsigned PON  = 20;
   localparam int unsigned WAKE = 3;
   localparam logic [27:0] CH_A = 28'h00C0C0A;
   localparam logic [27:0] CH_B = 28'hFFDFFFF;
   localparam logic [27:0] CH_C = 28'h0100805;
   logic        clk_sys_i         = 1'b0;
   logic        sys_rst_i         = 1'b1;
   logic        program_trigger_i = 1'b1;
   logic [7:0]  reg_addr_i        = 8'h00;
   logic [31:0] reg_wdata_i       = 32'h0;
   logic        reg_wr_i          = 1'b0;
   logic        reg_rd_i          = 1'b0;
   logic [27:0] channel           = CH_A;
   logic        presc_q           = 1'b0;
   logic [3:0]  nibble_in_i;
   logic        prescaled_input_i;
   logic [31:0] reg_rdata_o;
   logic [2:0]  word_select_o;
   logic        word_select_oe_o;
   logic        memory_power_enable_n_o;
   logic        memory_power_enable_oe_o;
   logic        prescaler_modulus_select_o;
   logic        coarse_phase_out_o;
   logic        coarse_phase_oe_o;
   logic        lock_indicator_n_o;
   logic        lock_indicator_oe_o;
   int          failures  = 0;
   int          tests_run = 0;
   int          n;
   int          m;

   always #5 clk_sys_i = ~clk_sys_i;

   spld_top #(.POWER_ON_DELAY(PON), .MEM_WAKE(WAKE)) i_spld_top (
      .clk_sys_i, .sys_rst_i, .nibble_in_i, .program_trigger_i, .prescaled_input_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .word_select_o,
      .word_select_oe_o, .memory_power_enable_n_o, .memory_power_enable_oe_o,
      .prescaler_modulus_select_o, .coarse_phase_out_o, .coarse_phase_oe_o,
      .lock_indicator_n_o, .lock_indicator_oe_o);

   spld_mem_model #(.WAKE(WAKE)) i_spld_mem_model (
      .clk_sys_i, .channel_i(channel), .word_select_i(word_select_o),
      .word_select_oe_i(word_select_oe_o),
      .mem_on_i(memory_power_enable_oe_o && !memory_power_enable_n_o),
      .modulus_i(prescaler_modulus_select_o), .nibble_o(nibble_in_i),
      .prescaled_o(prescaled_input_i));

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(logic [7:0] a, logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic reg_rd(logic [7:0] a, logic [31:0] exp, logic [31:0] m);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      check(reg_rdata_o & m, exp);
      @(posedge clk_sys_i);
   endtask

   task automatic wait_mem(logic lvl, int lim, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk_sys_i);
         cnt++;
      end while (memory_power_enable_oe_o !== lvl && cnt < lim);
      if (memory_power_enable_oe_o !== lvl) begin
         check(32'(memory_power_enable_oe_o), 32'(lvl));
         complete_run();
      end else begin
         @(posedge clk_sys_i);
      end
   endtask

   task automatic stay(logic lvl, int k);
      int bad;
      bad = 0;
      repeat (k) begin
         @(negedge clk_sys_i);
         if (memory_power_enable_oe_o !== lvl)
            bad++;
      end
      @(posedge clk_sys_i);
      check(32'(bad), 32'h0);
   endtask

   // Prescaler edges seen while the modulus line holds one level
   task automatic count_edges(logic lvl, output int cnt);
      logic rise;
      cnt = 0;
      repeat (400) begin
         @(negedge clk_sys_i);
         rise    = prescaled_input_i && !presc_q;
         presc_q = prescaled_input_i;
         if (prescaler_modulus_select_o !== lvl)
            break;
         if (rise)
            cnt++;
      end
      // Phase never ended within the bound
      if (prescaler_modulus_select_o === lvl) begin
         check(32'(prescaler_modulus_select_o), 32'(!lvl));
         complete_run();
      end
   endtask

   // Coarse output cycles showing divided-leads and reference-leads
   task automatic phase_window(output int lead, output int lag);
      lead = 0;
      lag  = 0;
      repeat (200) begin
         @(negedge clk_sys_i);
         if (coarse_phase_oe_o === 1'b1 && coarse_phase_out_o === 1'b1)
            lead++;
         if (coarse_phase_oe_o === 1'b1 && coarse_phase_out_o === 1'b0)
            lag++;
      end
   endtask

   initial begin
      repeat (9) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check({30'h0, word_select_oe_o, memory_power_enable_oe_o}, 32'h0);
      check(reg_rdata_o, 32'h0);
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      wait_mem(1'b1, PON + 20, n);
      check(32'(n >= PON && n <= PON + 3), 32'h1);
      wait_mem(1'b0, 2000, n);
      check(32'(n > 960 && n <= 1030), 32'h1);
      reg_rd(spld_pkg::OFS_CHANNEL, {4'h0, CH_A}, 32'hFFFFFFFF);
      reg_rd(8'hFC, 32'h0, 32'hFFFFFFFF);
      count_edges(1'b0, n);
      count_edges(1'b1, n);
      count_edges(1'b0, n);
      check(32'(n), 32'h3);
      count_edges(1'b1, n);
      check(32'(n), 32'h7);
      // Reference divides by 12, divided chain by 43: reference leads
      phase_window(n, m);
      check(32'(n), 32'h0);
      check(32'(m != 0), 32'h1);
      @(posedge clk_sys_i);
      channel           <= CH_C;
      program_trigger_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      program_trigger_i <= 1'b1;
      wait_mem(1'b0, 2000, n);
      stay(1'b0, 200);
      reg_rd(spld_pkg::OFS_CHANNEL, {4'h0, CH_C}, 32'hFFFFFFFF);
      channel <= CH_B;
      reg_wr(spld_pkg::OFS_CTRL, 32'h1);
      reg_wr(spld_pkg::OFS_CTRL, 32'h1);
      reg_rd(spld_pkg::OFS_STATUS, 32'h1, 32'h3);
      wait_mem(1'b0, 2000, n);
      stay(1'b0, 200);
      reg_rd(spld_pkg::OFS_CHANNEL, {4'h0, CH_B}, 32'hFFFFFFFF);
      channel           <= CH_A;
      program_trigger_i <= 1'b0;
      wait_mem(1'b1, 20, n);
      stay(1'b1, 2200);
      reg_rd(spld_pkg::OFS_STATUS, 32'h3, 32'h3);
      program_trigger_i <= 1'b1;
      wait_mem(1'b0, 1200, n);
      stay(1'b0, 200);
      reg_rd(spld_pkg::OFS_CHANNEL, {4'h0, CH_A}, 32'hFFFFFFFF);
      complete_run();
   end
endmodule // tb

bind spld_top spld_top_asserts #(.MEM_WAKE(MEM_WAKE)) i_spld_top_asserts (
   .clk_sys_i, .sys_rst_i, .program_trigger_i, .word_select_o, .word_select_oe_o,
   .memory_power_enable_n_o, .memory_power_enable_oe_o, .coarse_phase_oe_o,
   .lock_indicator_n_o, .lock_indicator_oe_o);
